// ---- pkg/fwr_pkg.sv ----
// constants, pin bundle and state codes for the fifo write, reset and flag setup block
package fwr_pkg;
	localparam int          DATA_W         = 18;
	localparam int          ADDR_W         = 11;
	localparam int          PTR_W          = 12;
	localparam int          OFS_W          = 10;
	localparam int          PIN_W          = 24;
	localparam logic [11:0] DEPTH          = 12'h800;
	localparam logic [11:0] HALF_LEVEL     = 12'h400;
	localparam logic [9:0]  DEFAULT_OFFSET = 10'h100;
	localparam logic [9:0]  OFFSET_RESET   = 10'h000;
	localparam logic [2:0]  RESET_EDGES    = 3'h4;
	localparam logic [1:0]  READY_EDGES    = 2'h2;

	typedef struct packed {
		logic        fifo_reset_n;
		logic        write_clock_in;
		logic        read_clock_in;
		logic        write_enable_a;
		logic        write_enable_b;
		logic        offset_define_strobe;
		logic [17:0] data_input_bus;
	} fwr_pins_t;

	typedef enum logic [1:0] {
		FWR_RESET  = 2'b00,
		FWR_ARMING = 2'b01,
		FWR_RUN    = 2'b10,
		FWR_HALTED = 2'b11
	} fwr_state_t;
endpackage

// ---- verilog/fwr_sync.sv ----
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
module fwr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// the first stage feeds only the second
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;
endmodule

// ---- verilog/fwr_fifo_write.sv ----
// write port, reset sequence and flag thresholds of an 18 bit by 2048 word fifo
// Function
// - completed reset clears write pointer, drops half and space flags, raises near
// - strobe low at reset uses stored offset
// - strobe high through reset uses 256
// - write only when space and both enables
// - space flag changes only on write edges
// - offset capture ignores the write enables
// - offset is low ten data bits
// - half at word 1025, limit 2049 minus offset
// - space high second write edge after reset
// - half flag high at 1025 words or more
`timescale 1ns/1ns
module fwr_fifo_write (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire fwr_pkg::fwr_pins_t     pins,
	input  wire logic [11:0]            read_pointer,
	output logic                        space_available_flag,
	output logic                        half_full_flag,
	output logic                        near_limit_flag,
	output logic [11:0]                 write_pointer,
	output logic [17:0]                 read_word
);
	import fwr_pkg::*;

	fwr_pins_t          pins_s;
	fwr_state_t         state_reg,   state_next;
	logic [PTR_W-1:0]   wptr_reg,    wptr_next;
	logic [2:0]         wcnt_reg,    wcnt_next;
	logic [2:0]         rcnt_reg,    rcnt_next;
	logic [1:0]         arm_reg,     arm_next;
	logic               all_high_reg, all_high_next;
	logic [OFS_W-1:0]   stored_reg,  stored_next;
	logic [OFS_W-1:0]   offset_reg,  offset_next;
	logic               space_reg,   space_next;
	logic               half_reg,    half_next;
	logic               near_reg,    near_next;
	logic [DATA_W-1:0]  rword_reg,   rword_next;
	logic               wclk_d_reg,  rclk_d_reg, strobe_d_reg;
	logic               wrise;
	logic               rrise;
	logic               strobe_fall;
	logic               write_go;
	logic [PTR_W-1:0]   count;
	logic [PTR_W-1:0]   count_after;
	logic [PTR_W-1:0]   offset_w;
	logic [DATA_W-1:0]  mem [0:2047];

	// every pin, data included, is resynchronised; data and clock pass the same delay
	fwr_sync #(.W(PIN_W)) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     (pins),
		.q     (pins_s)
	);

	// the write clock is sampled, so it must stay well below half of clk
	assign wrise       = pins_s.write_clock_in & ~wclk_d_reg;
	assign rrise       = pins_s.read_clock_in & ~rclk_d_reg;
	assign strobe_fall = ~pins_s.offset_define_strobe & strobe_d_reg;
	assign write_go    = (state_reg == FWR_RUN) && wrise && space_reg
			&& pins_s.write_enable_a && pins_s.write_enable_b;
	assign count       = wptr_reg - read_pointer;
	assign count_after = wptr_next - read_pointer;
	assign offset_w    = {2'h0, offset_reg};

	always_comb
	begin
		state_next    = state_reg;
		wptr_next     = wptr_reg;
		wcnt_next     = wcnt_reg;
		rcnt_next     = rcnt_reg;
		arm_next      = arm_reg;
		all_high_next = all_high_reg;
		offset_next   = offset_reg;
		space_next    = space_reg;
		stored_next   = stored_reg;
		// enables play no part in capturing the offset
		if (strobe_fall)
			stored_next = pins_s.data_input_bus[OFS_W-1:0];
		if (!pins_s.fifo_reset_n)
		begin
			if (state_reg != FWR_RESET)
			begin
				state_next    = FWR_RESET;
				wcnt_next     = 3'h0;
				rcnt_next     = 3'h0;
				all_high_next = 1'b1;
			end
			wptr_next = '0;
			if (wrise && wcnt_reg != RESET_EDGES)
				wcnt_next = wcnt_reg + 3'h1;
			if (rrise && rcnt_reg != RESET_EDGES)
				rcnt_next = rcnt_reg + 3'h1;
			if (!pins_s.offset_define_strobe)
				all_high_next = 1'b0;
			if (wrise)
				space_next = 1'b0;
		end
		else
		begin
			case (state_reg)
				FWR_RESET:
				begin
					// a short reset leaves the write side shut until a proper one
					if (wcnt_reg == RESET_EDGES && rcnt_reg == RESET_EDGES)
					begin
						state_next  = FWR_ARMING;
						arm_next    = 2'h0;
						offset_next = all_high_reg ? DEFAULT_OFFSET : stored_reg;
					end
					else
						state_next = FWR_HALTED;
				end
				FWR_ARMING:
				begin
					if (wrise)
					begin
						arm_next = arm_reg + 2'h1;
						if (arm_reg == READY_EDGES - 2'h1)
						begin
							state_next = FWR_RUN;
							space_next = 1'b1;
						end
					end
				end
				FWR_RUN:
				begin
					if (write_go)
						wptr_next = wptr_reg + 12'h001;
					if (wrise)
						space_next = (count_after < DEPTH);
				end
				default:
				begin
					state_next = FWR_HALTED;
				end
			endcase
		end
	end

	always_comb
	begin
		rword_next = mem[read_pointer[ADDR_W-1:0]];
		if (state_reg == FWR_RESET)
		begin
			half_next = 1'b0;
			near_next = 1'b1;
		end
		else
		begin
			half_next = (count >= HALF_LEVEL);
			// the read side holds the first word outside memory, so count trails the word number
			near_next = (count <= offset_w) || (count >= DEPTH - offset_w);
		end
	end

	always_ff @(posedge clk)
	begin
		if (write_go)
			mem[wptr_reg[ADDR_W-1:0]] <= pins_s.data_input_bus;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg    <= FWR_RESET;
			wptr_reg     <= '0;
			wcnt_reg     <= 3'h0;
			rcnt_reg     <= 3'h0;
			arm_reg      <= 2'h0;
			all_high_reg <= 1'b1;
			stored_reg   <= OFFSET_RESET;
			offset_reg   <= DEFAULT_OFFSET;
			space_reg    <= 1'b0;
			half_reg     <= 1'b0;
			near_reg     <= 1'b1;
			rword_reg    <= '0;
			wclk_d_reg   <= 1'b0;
			rclk_d_reg   <= 1'b0;
			strobe_d_reg <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			wptr_reg     <= wptr_next;
			wcnt_reg     <= wcnt_next;
			rcnt_reg     <= rcnt_next;
			arm_reg      <= arm_next;
			all_high_reg <= all_high_next;
			stored_reg   <= stored_next;
			offset_reg   <= offset_next;
			space_reg    <= space_next;
			half_reg     <= half_next;
			near_reg     <= near_next;
			rword_reg    <= rword_next;
			wclk_d_reg   <= pins_s.write_clock_in;
			rclk_d_reg   <= pins_s.read_clock_in;
			strobe_d_reg <= pins_s.offset_define_strobe;
		end
	end

	assign space_available_flag = space_reg;
	assign half_full_flag       = half_reg;
	assign near_limit_flag      = near_reg;
	assign write_pointer        = wptr_reg;
	assign read_word            = rword_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_reset_flags: assert property ((state_reg == FWR_RESET) |=> !half_full_flag && near_limit_flag)
		else $error("flags wrong during reset");
	a_reset_ptr: assert property (!pins_s.fifo_reset_n |=> write_pointer == 12'h000)
		else $error("write pointer not cleared in reset");
	a_default_ofs: assert property ((state_reg == FWR_RESET && state_next == FWR_ARMING && all_high_reg)
		|=> offset_reg == DEFAULT_OFFSET)
		else $error("default offset not taken");
	a_stored_ofs: assert property ((state_reg == FWR_RESET && state_next == FWR_ARMING && !all_high_reg)
		|=> offset_reg == $past(stored_reg))
		else $error("stored offset not taken");
	a_write_gate: assert property ((state_reg == FWR_RUN && pins_s.fifo_reset_n && !write_go)
		|=> $stable(wptr_reg))
		else $error("pointer moved without a valid write");
	a_write_step: assert property (write_go && pins_s.fifo_reset_n |=> wptr_reg == $past(wptr_reg) + 12'h001)
		else $error("valid write not stored");
	a_space_edge: assert property ($changed(space_available_flag) |-> $past(wrise))
		else $error("space flag moved off a write edge");
	a_ready_second: assert property ((state_reg == FWR_ARMING && wrise && arm_reg == 2'h1
		&& pins_s.fifo_reset_n) |=> space_available_flag && state_reg == FWR_RUN)
		else $error("space flag late after reset");
	a_half_level: assert property ((state_reg == FWR_RUN) |=> half_full_flag == ($past(count) >= HALF_LEVEL))
		else $error("half full flag wrong");
	a_ofs_capture: assert property (strobe_fall |=> stored_reg == $past(pins_s.data_input_bus[OFS_W-1:0]))
		else $error("offset not captured on strobe fall");

	c_default_run: cover property (state_reg == FWR_ARMING && all_high_reg ##[1:50] state_reg == FWR_RUN);
	c_half_full: cover property ($rose(half_full_flag));
	c_full: cover property ($fell(space_available_flag) && state_reg == FWR_RUN);
	c_near_drop: cover property ($fell(near_limit_flag));
endmodule

// ---- tb/fwr_host_model.sv ----
// host side model: free-running write and read clocks around the bench pin levels
`timescale 1ns/1ns
module fwr_host_model (
	input  wire logic         rst_n,
	input  wire logic [1:0]   en,
	input  wire logic         stb,
	input  wire logic [17:0]  data,
	output fwr_pkg::fwr_pins_t pins
);
	import fwr_pkg::*;
	logic wclk;
	logic rclk;
	initial
	begin
		wclk = 1'b0;
		forever #200 wclk = ~wclk;
	end
	// read clock offset in phase; it also runs through reset so edges get counted
	initial
	begin
		rclk = 1'b0;
		#130;
		forever #200 rclk = ~rclk;
	end
	assign pins = '{rst_n, wclk, rclk, en[0], en[1], stb, data};
endmodule

// ---- tb/fwr_fifo_write_tb.sv ----
// self-checking bench for the fifo write port, reset sequence and flag thresholds
`timescale 1ns/1ns
module fwr_fifo_write_tb;
	import fwr_pkg::*;
	logic        clk;
	logic        reset;
	logic        rst_n;
	logic [1:0]  en;
	logic        stb;
	logic [17:0] data;
	fwr_pins_t   pins;
	logic        space;
	logic        half;
	logic        near;
	logic [11:0] wp;
	logic [17:0] rword;
	logic [11:0] rp;
	int          n_errors;
	int          checked;
	int          i;

	fwr_host_model host_u (.rst_n(rst_n), .en(en), .stb(stb), .data(data), .pins(pins));
	fwr_fifo_write dut_u (.clk(clk), .reset(reset), .pins(pins), .read_pointer(rp),
		.space_available_flag(space), .half_full_flag(half), .near_limit_flag(near),
		.write_pointer(wp), .read_word(rword));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task step;
		@(posedge clk);
		#5;
	endtask

	task chk(input logic [17:0] got, input logic [17:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task end_sim;
		if (n_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// enables rise and fall just after a write rise, so exactly n rises see them
	task wr(input int n, input logic [1:0] e, input logic [17:0] d);
		@(posedge pins.write_clock_in);
		step;
		en = e;
		data = d;
		repeat (n) @(posedge pins.write_clock_in);
		step;
		en = 2'b00;
		repeat (6) step;
	endtask

	task rst(input int n, input logic s);
		step;
		stb = s;
		rst_n = 1'b0;
		rp = 12'h000;
		repeat (n) @(posedge pins.write_clock_in);
		step;
		if (n > 3)
		begin
			chk(wp, 12'h000);
			chk(half, 1'b0);
			chk(near, 1'b1);
			chk(space, 1'b0);
		end
		rst_n = 1'b1;
		for (i = 0; i < 40 && space !== 1'b1; i++)
			step;
	endtask

	initial
	begin
		reset = 1'b1;
		rst_n = 1'b1;
		en = 2'b00;
		stb = 1'b1;
		data = 18'h00000;
		rp = 12'h000;
		n_errors = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		#5;
		reset = 1'b0;
		rst(6, 1'b1);
		chk(space, 1'b1);
		wr(1, 2'b11, 18'h2A5A5);
		chk(wp, 12'h001);
		chk(rword, 18'h2A5A5);
		// the read side moves the first word out to its output stage
		rp = 12'h001;
		wr(3, 2'b01, 18'h15A5A);
		wr(3, 2'b10, 18'h15A5A);
		chk(wp, 12'h001);
		wr(256, 2'b11, 18'h3C3C3);
		chk(near, 1'b1);
		chk(rword, 18'h3C3C3);
		wr(1, 2'b11, 18'h3C3C3);
		chk(near, 1'b0);
		wr(766, 2'b11, 18'h3C3C3);
		chk(half, 1'b0);
		wr(1, 2'b11, 18'h3C3C3);
		chk(half, 1'b1);
		wr(767, 2'b11, 18'h3C3C3);
		chk(near, 1'b0);
		wr(1, 2'b11, 18'h3C3C3);
		chk(near, 1'b1);
		wr(255, 2'b11, 18'h3C3C3);
		chk(space, 1'b1);
		wr(1, 2'b11, 18'h3C3C3);
		chk(space, 1'b0);
		wr(2, 2'b11, 18'h3C3C3);
		chk(wp, 12'h801);
		// offset 100 in the low bits, upper bits set to prove they are ignored
		// enables high while full: capture must not care about them
		step;
		data = 18'h3FC64;
		en = 2'b11;
		repeat (4) step;
		stb = 1'b0;
		repeat (4) step;
		data = 18'h00000;
		en = 2'b00;
		rst(2, 1'b0);
		wr(2, 2'b11, 18'h01234);
		chk(space, 1'b0);
		chk(wp, 12'h000);
		rst(6, 1'b0);
		chk(space, 1'b1);
		wr(1, 2'b11, 18'h0F0F0);
		chk(rword, 18'h0F0F0);
		rp = 12'h001;
		wr(100, 2'b11, 18'h0F0F0);
		chk(near, 1'b1);
		wr(1, 2'b11, 18'h0F0F0);
		chk(near, 1'b0);
		wr(1846, 2'b11, 18'h0F0F0);
		chk(near, 1'b0);
		wr(1, 2'b11, 18'h0F0F0);
		chk(near, 1'b1);
		end_sim;
	end

	initial
	begin
		#3000000;
		n_errors++;
		end_sim;
	end
endmodule
